// ==== rtl/echo_curve_pkg.sv ====
// What this block does
// R1 - temperature code readable at index zero
// R2 - type one uses table two, else one
// R3 - threshold timing from burst, ends 60 ms
// R4 - twelve entries: 6-bit level, 4-bit time
// R5 - linear ramp to each entry level
// R6 - levels linear, 63 is full scale
// R7 - threshold time codes map 100..8000 us
// R8 - hold twelfth level after last time
// R9 - noise monitoring uses separate noise threshold
// R10 - 15-byte table frames at index 5, 6
// R11 - frames carried lsb first, bit 0 first
// R12 - gain curve interpolated like threshold, five segments
// R13 - gain time codes map 102.4..20070.4 us
// R14 - gain low-pass filter updated at 2.5 MHz
// R15 - bandwidth code picks shift 0/8/9/10
// R16 - gain start delayed by code times 204.8 us
// R17 - five signed 7-bit steps at index 8
// R18 - steps added to base gain, saturated
package echo_curve_pkg;
	localparam logic [3:0] CFG_IDX_TEMP   = 4'h0;
	localparam logic [3:0] CFG_IDX_TBL_A  = 4'h5;
	localparam logic [3:0] CFG_IDX_TBL_B  = 4'h6;
	localparam logic [3:0] CFG_IDX_GAIN   = 4'h8;
	localparam int         FRAME_W        = 120;
	localparam int         GCFG_W         = 66;
	localparam int         LVL_W          = 6;
	localparam int         THR_LAST       = 11;
	localparam int         THR_GROUP_W    = 24;
	localparam int         THR_DT_POS     = 72;
	localparam int         GAIN_SEGS      = 5;
	localparam int         GSTEP_W        = 8;
	localparam int         GDT_POS        = 40;
	localparam int         GSTART_POS     = 60;
	localparam int         GBW_POS        = 64;
	localparam int         CLK_FREQ_KHZ   = 40000;
	localparam int         CYC_PER_US     = CLK_FREQ_KHZ / 1000;
	localparam int         THR_END_US     = 60000;
	localparam int         FILT_RATE_KHZ  = 2500;
	localparam int         FILT_TICK_CYC  = CLK_FREQ_KHZ / FILT_RATE_KHZ;
	localparam int         FILT_FRAC      = 10;
	localparam int         GSTART_TENTHS  = 2048;
	localparam logic [6:0] GAIN_MAX       = 7'h7f;
	localparam int THR_DT_US [16] = '{100, 200, 300, 400, 600, 800, 1000, 1200,
		1600, 2000, 2400, 3200, 4000, 5200, 6400, 8000};
	localparam int GAIN_DT_TENTHS [16] = '{1024, 2048, 4096, 8192, 12288, 16384,
		20480, 24576, 32768, 45056, 59392, 79872, 100352, 126976, 159744, 200704};
	localparam int FILT_SHIFT [4] = '{0, 8, 9, 10};
endpackage

// ==== rtl/echo_threshold_gain_curves.sv ====
`timescale 1ns/1ps
module echo_threshold_gain_curves
	import echo_curve_pkg::*;
#(
	parameter int CYC_PER_US_P = CYC_PER_US,
	parameter int THR_END_CYC  = THR_END_US * CYC_PER_US
) (
	input  wire logic                 sys_clk_in,
	input  wire logic                 reset_in,
	input  wire logic                 cfg_wr_in,
	input  wire logic                 cfg_rd_in,
	input  wire logic [3:0]           cfg_idx_in,
	input  wire logic [FRAME_W-1:0]   cfg_frame_in,
	input  wire logic [7:0]           temp_code_in,
	input  wire logic                 meas_start_in,
	input  wire logic                 meas_type_in,
	input  wire logic                 meas_end_in,
	input  wire logic                 noise_mon_in,
	input  wire logic [LVL_W-1:0]     noise_floor_threshold_in,
	input  wire logic [6:0]           base_gain_in,
	input  wire logic                 dyn_gain_ena_in,
	output logic      [FRAME_W-1:0]   rd_frame_out,
	output logic                      meas_active_out,
	output logic      [LVL_W-1:0]     threshold_out,
	output logic      [6:0]           gain_out
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [0:0] {PH_IDLE = 1'b0, PH_RUN = 1'b1} phase_t;

	typedef struct packed {
		phase_t               phase;
		logic                 thr_sel;
		logic [FRAME_W-1:0]   tbl_a;
		logic [FRAME_W-1:0]   tbl_b;
		logic [GCFG_W-1:0]    gcfg;
		logic [FRAME_W-1:0]   rd_frame;
		logic [23:0]          elapsed;
		logic [3:0]           thr_idx;
		logic                 thr_done;
		logic [23:0]          thr_cnt;
		logic [23:0]          thr_acc;
		logic [LVL_W-1:0]     thr_lvl;
		logic [LVL_W-1:0]     thr_out;
		logic [2:0]           g_seg;
		logic                 g_started;
		logic                 g_done;
		logic [23:0]          g_cnt;
		logic [23:0]          g_acc;
		logic signed [10:0]   g_x;
		logic signed [10:0]   g_base;
		logic [3:0]           flt_div;
		logic [17:0]          flt_y;
		logic [6:0]           gain;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	localparam int GSTART_CYC = GSTART_TENTHS * CYC_PER_US_P / 10;

	// ----------------------------------------
	// decoding
	// ----------------------------------------
	// every fourth level is split in 2-bit pieces over three bytes
	function automatic logic [LVL_W-1:0] lvl_of(input logic [FRAME_W-1:0] f, input int i);
		int g;
		int k;
		g = (i / 4) * THR_GROUP_W;
		k = i % 4;
		if (k == 3) begin
			lvl_of = {f[g+23 -: 2], f[g+15 -: 2], f[g+7 -: 2]};
		end else begin
			lvl_of = f[g+k*8 +: LVL_W];
		end
	endfunction

	function automatic logic [23:0] thr_cyc(input logic [FRAME_W-1:0] f, input int i);
		thr_cyc = 24'(THR_DT_US[f[THR_DT_POS+i*4 +: 4]] * CYC_PER_US_P);
	endfunction

	function automatic logic [23:0] gain_cyc(input logic [GCFG_W-1:0] f, input int i);
		gain_cyc = 24'(GAIN_DT_TENTHS[f[GDT_POS+i*4 +: 4]] * CYC_PER_US_P / 10);
	endfunction

	function automatic logic [6:0] sat_gain(input logic signed [10:0] x);
		if (x < 0) begin
			sat_gain = 7'h00;
		end else if (x > $signed({4'h0, GAIN_MAX})) begin
			sat_gain = GAIN_MAX;
		end else begin
			sat_gain = x[6:0];
		end
	endfunction

	logic [FRAME_W-1:0]   tbl;
	logic [LVL_W-1:0]     tgt;
	logic [LVL_W-1:0]     prv;
	logic [LVL_W-1:0]     thr_d;
	logic [23:0]          thr_sum;
	logic [23:0]          thr_dur;
	logic [6:0]           g_mag;
	logic                 g_neg;
	logic [23:0]          g_sum;
	logic [23:0]          g_dur;
	logic [16:0]          flt_x;
	int                   s;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		tbl = st_ff.thr_sel ? st_ff.tbl_b : st_ff.tbl_a; // R2
		tgt = lvl_of(tbl, int'(st_ff.thr_idx));
		prv = (st_ff.thr_idx == 4'h0) ? tgt : lvl_of(tbl, int'(st_ff.thr_idx) - 1);
		thr_d = (tgt > prv) ? tgt - prv : prv - tgt;
		thr_sum = st_ff.thr_acc + 24'(thr_d);
		thr_dur = thr_cyc(tbl, int'(st_ff.thr_idx)); // R7
		g_mag = st_ff.gcfg[int'(st_ff.g_seg)*GSTEP_W +: 7]; // R17
		g_neg = st_ff.gcfg[int'(st_ff.g_seg)*GSTEP_W + 7];
		g_sum = st_ff.g_acc + 24'(g_mag);
		g_dur = gain_cyc(st_ff.gcfg, int'(st_ff.g_seg)); // R13
		s = FILT_SHIFT[st_ff.gcfg[GBW_POS +: 2]]; // R15
		flt_x = {sat_gain(st_ff.g_x), 10'h000}; // R18

		// frame bit 0 is the first bit on the line, kept at index 0
		if (cfg_wr_in) begin
			case (cfg_idx_in)
				CFG_IDX_TBL_A: nxt_st.tbl_a = cfg_frame_in; // R10 R11
				CFG_IDX_TBL_B: nxt_st.tbl_b = cfg_frame_in; // R10 R11
				CFG_IDX_GAIN:  nxt_st.gcfg = cfg_frame_in[GCFG_W-1:0]; // R17
				default: ;
			endcase
		end
		if (cfg_rd_in) begin
			case (cfg_idx_in)
				CFG_IDX_TEMP:  nxt_st.rd_frame = {112'h0, temp_code_in}; // R1
				CFG_IDX_TBL_A: nxt_st.rd_frame = st_ff.tbl_a;
				CFG_IDX_TBL_B: nxt_st.rd_frame = st_ff.tbl_b;
				CFG_IDX_GAIN:  nxt_st.rd_frame = {54'h0, st_ff.gcfg};
				default:       nxt_st.rd_frame = '0;
			endcase
		end

		if (meas_start_in) begin
			nxt_st.phase = PH_RUN;
			nxt_st.thr_sel = meas_type_in; // R2
			nxt_st.elapsed = 24'h000000; // R3
			nxt_st.thr_idx = 4'h0;
			nxt_st.thr_done = 1'b0;
			nxt_st.thr_cnt = 24'h000000;
			nxt_st.thr_acc = 24'h000000;
			nxt_st.thr_lvl = lvl_of(meas_type_in ? st_ff.tbl_b : st_ff.tbl_a, 0); // R4
			nxt_st.g_seg = 3'h0;
			nxt_st.g_started = 1'b0;
			nxt_st.g_done = 1'b0;
			nxt_st.g_cnt = 24'h000000;
			nxt_st.g_acc = 24'h000000;
			nxt_st.g_x = $signed({4'h0, base_gain_in}); // R18
			nxt_st.g_base = $signed({4'h0, base_gain_in});
		end else if (st_ff.phase == PH_RUN) begin
			if (meas_end_in) begin
				nxt_st.phase = PH_IDLE;
			end
			nxt_st.elapsed = st_ff.elapsed + 24'h000001;
			if (!st_ff.thr_done) begin
				if (st_ff.elapsed >= 24'(THR_END_CYC - 1)) begin
					nxt_st.thr_done = 1'b1; // R3
					nxt_st.thr_lvl = lvl_of(tbl, THR_LAST);
				end else if (st_ff.thr_cnt >= thr_dur - 24'h000001) begin
					nxt_st.thr_lvl = tgt;
					nxt_st.thr_cnt = 24'h000000;
					nxt_st.thr_acc = 24'h000000;
					if (st_ff.thr_idx == 4'(THR_LAST)) begin
						nxt_st.thr_done = 1'b1; // R8
					end else begin
						nxt_st.thr_idx = st_ff.thr_idx + 4'h1;
					end
				end else begin
					// error-diffusion ramp: never more than one code per clock
					nxt_st.thr_cnt = st_ff.thr_cnt + 24'h000001;
					nxt_st.thr_acc = thr_sum;
					if (thr_sum >= thr_dur) begin // R5 R6
						nxt_st.thr_acc = thr_sum - thr_dur;
						if (st_ff.thr_lvl < tgt) begin
							nxt_st.thr_lvl = st_ff.thr_lvl + 6'h01;
						end else if (st_ff.thr_lvl > tgt) begin
							nxt_st.thr_lvl = st_ff.thr_lvl - 6'h01;
						end
					end
				end
			end
			if (!st_ff.g_started) begin
				if (dyn_gain_ena_in &&
					st_ff.elapsed == 24'(int'(st_ff.gcfg[GSTART_POS +: 4]) * GSTART_CYC)) begin
					nxt_st.g_started = 1'b1; // R16
				end
			end else if (!st_ff.g_done) begin
				if (st_ff.g_cnt >= g_dur - 24'h000001) begin
					nxt_st.g_x = g_neg ? st_ff.g_base - $signed({4'h0, g_mag})
						: st_ff.g_base + $signed({4'h0, g_mag});
					nxt_st.g_base = nxt_st.g_x;
					nxt_st.g_cnt = 24'h000000;
					nxt_st.g_acc = 24'h000000;
					if (st_ff.g_seg == 3'(GAIN_SEGS - 1)) begin
						nxt_st.g_done = 1'b1;
					end else begin
						nxt_st.g_seg = st_ff.g_seg + 3'h1;
					end
				end else begin
					nxt_st.g_cnt = st_ff.g_cnt + 24'h000001;
					nxt_st.g_acc = g_sum;
					if (g_sum >= g_dur) begin // R12
						nxt_st.g_acc = g_sum - g_dur;
						nxt_st.g_x = g_neg ? st_ff.g_x - 11'sd1 : st_ff.g_x + 11'sd1;
					end
				end
			end
		end else begin
			nxt_st.g_x = $signed({4'h0, base_gain_in});
		end

		nxt_st.thr_out = noise_mon_in ? noise_floor_threshold_in : nxt_st.thr_lvl; // R9

		// filter state keeps 10 fraction bits so slow settings still move
		if (st_ff.flt_div == 4'(FILT_TICK_CYC - 1)) begin
			nxt_st.flt_div = 4'h0;
			if (s == 0) begin
				nxt_st.flt_y = {1'b0, flt_x}; // R15
			end else begin
				nxt_st.flt_y = st_ff.flt_y - (st_ff.flt_y >> s) + 18'(flt_x >> s); // R14
			end
		end else begin
			nxt_st.flt_div = st_ff.flt_div + 4'h1;
		end
		nxt_st.gain = st_ff.flt_y[FILT_FRAC +: 7];
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign rd_frame_out    = st_ff.rd_frame;
	assign meas_active_out = (st_ff.phase == PH_RUN);
	assign threshold_out   = st_ff.thr_out;
	assign gain_out        = st_ff.gain;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	temp_read_a: assert property (cfg_rd_in && cfg_idx_in == CFG_IDX_TEMP |=> // R1
		rd_frame_out == {112'h0, $past(temp_code_in)}) else $error("temp read wrong");
	table_pick_a: assert property (meas_start_in |=> st_ff.thr_sel == $past(meas_type_in)) // R2
		else $error("table select wrong");
	thr_end_a: assert property (st_ff.phase == PH_RUN && !meas_start_in // R3
		&& st_ff.elapsed == 24'(THR_END_CYC - 1) |=> st_ff.thr_done) else $error("60 ms end missed");
	// the forced stop at the time limit may jump straight to the last level
	ramp_step_a: assert property (meas_active_out && $past(meas_active_out) // R5
		&& !$past(noise_mon_in) && !$past(noise_mon_in, 2) && !$past(meas_start_in)
		&& $past(st_ff.elapsed) != 24'(THR_END_CYC - 1)
		|-> (threshold_out - $past(threshold_out) <= 6'h01)
		|| ($past(threshold_out) - threshold_out <= 6'h01)) else $error("ramp jumped");
	thr_step_a: assert property (st_ff.phase == PH_RUN && !meas_start_in && !st_ff.thr_done // R7
		&& st_ff.elapsed < 24'(THR_END_CYC - 1) && st_ff.thr_idx != 4'(THR_LAST)
		&& st_ff.thr_cnt == thr_dur - 24'h000001 |=> st_ff.thr_idx == $past(st_ff.thr_idx) + 4'h1)
		else $error("interval length wrong");
	hold_last_a: assert property (st_ff.thr_done && !meas_start_in && !cfg_wr_in // R8
		##1 !noise_mon_in && !meas_start_in && !cfg_wr_in
		|=> threshold_out == lvl_of(tbl, THR_LAST)) else $error("last level not held");
	noise_floor_threshold_a: assert property (noise_mon_in |=> threshold_out == $past(noise_floor_threshold_in)) // R9
		else $error("noise threshold not used");
	table_write_a: assert property (cfg_wr_in && cfg_idx_in == CFG_IDX_TBL_A // R11
		|=> st_ff.tbl_a == $past(cfg_frame_in)) else $error("table write lost");
	filter_pass_a: assert property (st_ff.flt_div == 4'(FILT_TICK_CYC - 1) && s == 0 // R15
		|=> st_ff.flt_y == {1'b0, $past(flt_x)} ##1 {gain_out, 10'h000} == $past(flt_x, 2))
		else $error("bypass filter wrong");
	gain_delay_a: assert property ($rose(st_ff.g_started) |-> $past(st_ff.elapsed) // R16
		== 24'(int'(st_ff.gcfg[GSTART_POS +: 4]) * GSTART_CYC)) else $error("gain start time");
	gain_sat_a: assert property (st_ff.flt_y <= {1'b0, GAIN_MAX, 10'h000}) // R18
		else $error("gain above limit");
	gain_seg_a: assert property (meas_active_out && !meas_start_in && st_ff.g_started // R13
		&& !st_ff.g_done && st_ff.g_cnt == g_dur - 24'h000001
		|=> st_ff.g_cnt == 24'h000000 && st_ff.g_base == st_ff.g_x)
		else $error("gain segment end wrong");
	filter_hold_a: assert property (st_ff.flt_div != 4'(FILT_TICK_CYC - 1) // R14
		|=> $stable(st_ff.flt_y)) else $error("filter moved off tick");
	first_level_a: assert property (meas_start_in && !noise_mon_in && !cfg_wr_in // R4
		|=> threshold_out == lvl_of(st_ff.thr_sel ? st_ff.tbl_b : st_ff.tbl_a, 0))
		else $error("first level wrong");

	run_cover_c: cover property (meas_start_in ##[1:20] st_ff.g_started);
	noise_cover_c: cover property (st_ff.phase == PH_RUN && noise_mon_in);
	seg_cover_c: cover property (st_ff.thr_idx == 4'h1 && st_ff.g_seg == 3'h1);
	done_cover_c: cover property (st_ff.thr_done && st_ff.g_done);
	smooth_cover_c: cover property (s == 8 && st_ff.flt_div == 4'(FILT_TICK_CYC - 1));

endmodule

// ==== sim/ecu_master_model.sv ====
`timescale 1ns/1ps
module ecu_master_model
	import echo_curve_pkg::*;
(
	input  wire logic               sys_clk_in,
	input  wire logic [FRAME_W-1:0] rd_frame_in,
	output logic                    cfg_wr_out,
	output logic                    cfg_rd_out,
	output logic      [3:0]         cfg_idx_out,
	output logic      [FRAME_W-1:0] cfg_frame_out
);
	initial begin
		cfg_wr_out = 1'b0;
		cfg_rd_out = 1'b0;
		cfg_idx_out = 4'hf;
		cfg_frame_out = '0;
	end
	// frame bit 0 is the first bit on the line
	task automatic xfer(input logic wr, input logic [3:0] idx,
		input logic [FRAME_W-1:0] f, output logic [FRAME_W-1:0] q);
		@(negedge sys_clk_in);
		cfg_wr_out = wr;
		cfg_rd_out = !wr;
		cfg_idx_out = idx;
		cfg_frame_out = f;
		@(negedge sys_clk_in);
		q = rd_frame_in;
		cfg_wr_out = 1'b0;
		cfg_rd_out = 1'b0;
		// released lines show junk, not the last value
		cfg_idx_out = ~idx;
		cfg_frame_out = ~f;
	endtask
endmodule

// ==== sim/echo_threshold_gain_curves_bench.sv ====
`timescale 1ns/1ps
module echo_threshold_gain_curves_bench;
	import echo_curve_pkg::*;
	logic               sys_clk_in = 1'b0;
	logic               reset_in, cfg_wr_in, cfg_rd_in, meas_start_in, meas_type_in;
	logic               meas_end_in, noise_mon_in, dyn_gain_ena_in, meas_active_out;
	logic [3:0]         cfg_idx_in;
	logic [FRAME_W-1:0] cfg_frame_in, rd_frame_out, q, f;
	logic [7:0]         temp_code_in;
	logic [5:0]         noise_floor_threshold_in, threshold_out;
	logic [6:0]         base_gain_in, gain_out, prev_gain;
	logic [5:0]         lv [2][12];
	int                 fails, samples_checked, seed, cyc, exp_y;
	always #12.5 sys_clk_in = ~sys_clk_in;
	echo_threshold_gain_curves #(.CYC_PER_US_P(1), .THR_END_CYC(3000)) u_echo_threshold_gain_curves (
		.sys_clk_in(sys_clk_in), .reset_in(reset_in), .cfg_wr_in(cfg_wr_in),
		.cfg_rd_in(cfg_rd_in), .cfg_idx_in(cfg_idx_in), .cfg_frame_in(cfg_frame_in),
		.temp_code_in(temp_code_in), .meas_start_in(meas_start_in),
		.meas_type_in(meas_type_in), .meas_end_in(meas_end_in),
		.noise_mon_in(noise_mon_in), .noise_floor_threshold_in(noise_floor_threshold_in),
		.base_gain_in(base_gain_in), .dyn_gain_ena_in(dyn_gain_ena_in),
		.rd_frame_out(rd_frame_out), .meas_active_out(meas_active_out),
		.threshold_out(threshold_out), .gain_out(gain_out));
	ecu_master_model u_ecu_master_model (
		.sys_clk_in(sys_clk_in), .rd_frame_in(rd_frame_out), .cfg_wr_out(cfg_wr_in),
		.cfg_rd_out(cfg_rd_in), .cfg_idx_out(cfg_idx_in), .cfg_frame_out(cfg_frame_in));
	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [FRAME_W-1:0] e, input logic [FRAME_W-1:0] s);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// every fourth level is split over the top bits of three bytes
	function automatic logic [FRAME_W-1:0] tbl(input int t);
		logic [FRAME_W-1:0] r;
		r = '0;
		for (int i = 0; i < 12; i++) begin
			r[72+4*i +: 4] = 4'(t);
			if (i % 4 != 3)
				r[8*(3*(i/4)+i%4) +: 6] = lv[t][i];
			else
				for (int k = 0; k < 3; k++)
					r[8*(3*(i/4)+k)+6 +: 2] = lv[t][i][2*k +: 2];
		end
		return r;
	endfunction
	// first-order smoothing, one update per filter tick
	function automatic int smooth(input int y, input int x, input int sh, input int n);
		for (int i = 0; i < n; i++)
			y = y - (y >> sh) + (x >> sh);
		return y;
	endfunction
	task automatic gain_run(input logic [6:0] b);
		base_gain_in = b;
		repeat (20) @(negedge sys_clk_in);
		meas_start_in = 1'b1;
		@(negedge sys_clk_in);
		meas_start_in = 1'b0;
		repeat (150) @(negedge sys_clk_in);
		chk("gain_delay", 120'(b), 120'(gain_out));
		repeat (650) @(negedge sys_clk_in);
		chk("gain_end", (b > 7'h66) ? 120'h7f : 120'(b + 7'h19), 120'(gain_out));
		meas_end_in = 1'b1;
		@(negedge sys_clk_in);
		meas_end_in = 1'b0;
	endtask
	initial begin
		seed = 76532;
		{reset_in, temp_code_in, noise_floor_threshold_in, base_gain_in} = {1'b1, 8'h00, 6'h00, 7'h00};
		{meas_start_in, meas_type_in, meas_end_in, noise_mon_in, dyn_gain_ena_in} = 5'h00;
		repeat (10) @(negedge sys_clk_in);
		reset_in = 1'b0;
		chk("threshold_rst", '0, 120'(threshold_out));
		repeat (3) begin
			temp_code_in = 8'($random(seed));
			u_ecu_master_model.xfer(1'b1, 4'h0, '1, q);
			u_ecu_master_model.xfer(1'b0, 4'h0, '0, q);
			chk("temp", {112'h0, temp_code_in}, q);
		end
		u_ecu_master_model.xfer(1'b0, 4'h3, '0, q);
		chk("unmapped", '0, q);
		for (int t = 0; t < 2; t++) begin
			for (int i = 0; i < 12; i++)
				lv[t][i] = 6'($random(seed));
			lv[t][1] = ~lv[t][0];
			u_ecu_master_model.xfer(1'b1, 4'(5 + t), tbl(t), q);
			u_ecu_master_model.xfer(1'b0, 4'(5 + t), '0, q);
			chk("table", tbl(t), q);
		end
		for (int t = 0; t < 2; t++) begin
			meas_type_in = t[0];
			meas_start_in = 1'b1;
			@(negedge sys_clk_in);
			meas_start_in = 1'b0;
			chk("thr_first", 120'(lv[t][0]), 120'(threshold_out));
			chk("active", 120'h1, 120'(meas_active_out));
			repeat (89 + 100 * t) @(negedge sys_clk_in);
			chk("thr_flat", 120'(lv[t][0]), 120'(threshold_out));
			repeat (111 + 100 * t) @(negedge sys_clk_in);
			chk("thr_ramp_end", 120'(lv[t][1]), 120'(threshold_out));
			repeat (2289 - 100 * t) @(negedge sys_clk_in);
			chk("thr_hold", 120'(lv[t][11]), 120'(threshold_out));
			noise_floor_threshold_in = 6'($random(seed));
			noise_mon_in = 1'b1;
			repeat (2) @(negedge sys_clk_in);
			chk("thr_noise", 120'(noise_floor_threshold_in), 120'(threshold_out));
			noise_mon_in = 1'b0;
			meas_end_in = 1'b1;
			@(negedge sys_clk_in);
			meas_end_in = 1'b0;
			@(negedge sys_clk_in);
			chk("inactive", '0, 120'(meas_active_out));
		end
		// step0 +40, step1 -15, codes 0, start 1, bypass filter
		f = '0;
		f[6:0] = 7'h28;
		f[15:8] = 8'h8f;
		f[63:60] = 4'h1;
		u_ecu_master_model.xfer(1'b1, 4'h8, f, q);
		u_ecu_master_model.xfer(1'b0, 4'h8, '0, q);
		chk("gain_cfg", f, q);
		dyn_gain_ena_in = 1'b1;
		gain_run(7'($random(seed)) & 7'h3f);
		gain_run(7'h78);
		// each bandwidth starts from a value settled in bypass
		for (int bw = 1; bw < 4; bw++) begin
			f = '0;
			u_ecu_master_model.xfer(1'b1, 4'h8, f, q);
			repeat (20) @(negedge sys_clk_in);
			f[65:64] = 2'(bw);
			u_ecu_master_model.xfer(1'b1, 4'h8, f, q);
			prev_gain = base_gain_in;
			base_gain_in = 7'($random(seed));
			repeat (16 * 64 + 2) @(negedge sys_clk_in);
			exp_y = smooth(int'(prev_gain) << FILT_FRAC, int'(base_gain_in) << FILT_FRAC,
				FILT_SHIFT[bw], 64);
			chk("gain_smooth", 120'(exp_y >> FILT_FRAC), 120'(gain_out));
		end
		end_of_test();
	end
endmodule
